// [epc_pkg.sv]
// Contract
// RQ1 - Taken jump or call redirects one cycle late
// RQ2 - Delay slot always runs; untaken continues sequentially
// RQ3 - Adjacent taken branches: first target replaces slot
// RQ4 - Second branch's successor skipped; continue at target
// RQ5 - Keep issuing while a memory access runs (a second load or store waits until it ends)
// RQ6 - Stall instructions needing a pending load result
// RQ7 - Stack pointer reads see the newest value
// RQ8 - Local register numbers use the stack pointer
// RQ9 - No interlock of stack pointer against locals
// RQ10 - Indirect local access unaffected by stack update
// RQ11 - Indirect pointer writes take effect next cycle
// RQ12 - Page size writes affect translation next cycle
// RQ13 - After a trap, delayed registers show new values
// RQ14 - Target issues right after slot, no bubble
package epc_pkg;
   localparam int PC_W     = 30;
   localparam int REG_W    = 8;
   localparam int WORD_W   = 32;
   localparam int PS_W     = 2;
   localparam int IP_NUM   = 3;
   localparam int LOC_W    = 7;
   localparam int LOCAL_BIT = 7;
   localparam int SP_IDX_LSB = 2;

   localparam logic [PC_W-1:0]   PC_RESET   = 30'h0;
   localparam logic [PC_W-1:0]   PC_STEP    = 30'h1;
   localparam logic [REG_W-1:0]  REG_INDIRECT = 8'h00;
   localparam logic [WORD_W-1:0] SP_RESET   = 32'h0;
   localparam logic [REG_W-1:0]  IP_RESET   = 8'h00;
   localparam logic [PS_W-1:0]   PS_RESET   = 2'h0;

   // Pointer index used by each operand slot
   localparam int IP_A = 0;
   localparam int IP_B = 1;
   localparam int IP_C = 2;

   typedef enum logic [1:0] {
      MEM_IDLE,
      MEM_LOAD,
      MEM_STORE
   } epc_mem_state_t;
endpackage

// [epc_if.sv]
`timescale 1ns/100ps
interface epc_if;
   import epc_pkg::*;
   logic                 spWe;
   logic [IP_NUM-1:0]    ipWe;
   logic                 psWe;
   logic                 trapTaken;
   logic [WORD_W-1:0]    wdata;
   logic [WORD_W-1:0]    spArch;
   logic [LOC_W-1:0]     spLocal;
   logic [REG_W-1:0]     ipEff [IP_NUM];
   logic [PS_W-1:0]      psEff;

   modport ctl  (output spWe, ipWe, psWe, trapTaken, wdata,
                 input  spArch, spLocal, ipEff, psEff);
   modport regs (input  spWe, ipWe, psWe, trapTaken, wdata,
                 output spArch, spLocal, ipEff, psEff);
endinterface

// [epc_regs.sv]
`timescale 1ns/100ps
module epc_regs
   import epc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic clkEn,
   // Pipeline side
   epc_if.regs       rf
);
   logic [WORD_W-1:0] sp;
   logic [LOC_W-1:0]  spLag;
   logic [PS_W-1:0]   ps;
   logic [PS_W-1:0]   psLag;

   wire [WORD_W-1:0] next_sp = rf.spWe ? rf.wdata : sp;
   wire [PS_W-1:0]   next_ps = rf.psWe ? rf.wdata[PS_W-1:0] : ps;

   // Architectural value is visible to the very next reader
   assign rf.spArch  = sp; // RQ7
   assign rf.spLocal = spLag;
   assign rf.psEff   = psLag;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sp    <= SP_RESET;
         spLag <= SP_RESET[SP_IDX_LSB +: LOC_W];
         ps    <= PS_RESET;
         psLag <= PS_RESET;
      end else if (clkEn) begin
         sp <= next_sp;
         ps <= next_ps;
         // Local base trails one cycle; no interlock against it
         spLag <= rf.trapTaken ? next_sp[SP_IDX_LSB +: LOC_W]
                               : sp[SP_IDX_LSB +: LOC_W]; // RQ9 RQ13
         psLag <= rf.trapTaken ? next_ps : ps; // RQ12 RQ13
      end
   end

   genvar i;
   generate
      for (i = 0; i < IP_NUM; i++) begin : g_ip
         logic [REG_W-1:0] ip;
         logic [REG_W-1:0] ipLag;
         wire  [REG_W-1:0] next_ip = rf.ipWe[i] ? rf.wdata[REG_W-1:0] : ip;
         assign rf.ipEff[i] = ipLag;
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               ip    <= IP_RESET;
               ipLag <= IP_RESET;
            end else if (clkEn) begin
               ip    <= next_ip;
               ipLag <= rf.trapTaken ? next_ip : ip; // RQ11 RQ13
            end
         end
      end
   endgenerate
endmodule

// [epc_pipe.sv]
`timescale 1ns/100ps
module epc_pipe
   import epc_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              clkEn,
   // Fetch address and decoded instruction at that address
   output logic [PC_W-1:0]        fetchAddr,
   input  wire logic              instValid,
   input  wire logic              instBranch,
   input  wire logic              instTaken,
   input  wire logic [PC_W-1:0]   instTarget,
   input  wire logic              instLoad,
   input  wire logic              instStore,
   input  wire logic [WORD_W-1:0] instMemAddr,
   input  wire logic [WORD_W-1:0] instStoreData,
   input  wire logic [REG_W-1:0]  instSrcA,
   input  wire logic [REG_W-1:0]  instSrcB,
   input  wire logic [REG_W-1:0]  instDest,
   input  wire logic              instUseA,
   input  wire logic              instUseB,
   input  wire logic              instUseDest,
   // Delayed-register writes by the issuing instruction; trap flag loads the delayed copies
   input  wire logic              instWriteSp,
   input  wire logic [IP_NUM-1:0] instWriteIp,
   input  wire logic              instWritePs,
   input  wire logic [WORD_W-1:0] instWriteData,
   input  wire logic              trapTaken,
   // Issue stream
   output logic                   issueValid,
   output logic [PC_W-1:0]        issuePc,
   output logic [REG_W-1:0]       issueSrcA,
   output logic [REG_W-1:0]       issueSrcB,
   output logic [REG_W-1:0]       issueDest,
   output logic [PS_W-1:0]        issuePageSize,
   output logic [WORD_W-1:0]      spValue,
   output logic                   stalled,
   // External memory channel
   output logic                   memReq,
   output logic                   memWe,
   output logic [WORD_W-1:0]      memAddr,
   output logic [WORD_W-1:0]      memWdata,
   output logic [PS_W-1:0]        memPageSize,
   input  wire logic              memAck,
   input  wire logic [WORD_W-1:0] memRdata,
   // Load write-back
   output logic                   wbValid,
   output logic [REG_W-1:0]       wbReg,
   output logic [WORD_W-1:0]      wbData
);
   epc_if rf ();

   epc_regs u_regs (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clkEn   (clkEn),
      .rf      (rf.regs)
   );

   epc_mem_state_t   memState;
   logic             redirPend;
   logic [PC_W-1:0]  redirTarget;
   logic [REG_W-1:0] loadDest;

   // Field 0 goes through a pointer, high half is stack relative
   function automatic logic [REG_W-1:0] absReg(
      input logic [REG_W-1:0] f,
      input logic [REG_W-1:0] ip,
      input logic [LOC_W-1:0] base
   );
      logic [LOC_W-1:0] sum;
      sum = LOC_W'(f[LOC_W-1:0] + base);
      if (f == REG_INDIRECT)
         return ip; // RQ10
      else if (f[LOCAL_BIT])
         return {1'b1, sum}; // RQ8
      else
         return f;
   endfunction

   wire [REG_W-1:0] absA = absReg(instSrcA, rf.ipEff[IP_A], rf.spLocal);
   wire [REG_W-1:0] absB = absReg(instSrcB, rf.ipEff[IP_B], rf.spLocal);
   wire [REG_W-1:0] absD = absReg(instDest, rf.ipEff[IP_C], rf.spLocal);

   wire loadPending = (memState == MEM_LOAD);
   wire memBusy     = (memState != MEM_IDLE);
   wire memOp       = instLoad | instStore;

   // Reading or writing the load target register holds issue back
   wire loadHit = loadPending &
                  ((instUseA & (absA == loadDest)) |
                   (instUseB & (absB == loadDest)) |
                   (instUseDest & (absD == loadDest))); // RQ6
   // One access in flight; other work keeps flowing past it
   wire memConflict = memOp & memBusy; // RQ5
   wire canIssue    = instValid & ~loadHit & ~memConflict; // RQ5
   wire memDone     = memReq & memAck;

   // Pending redirect from the previous taken branch wins over
   // sequential flow; a taken branch in the slot arms the next one
   wire [PC_W-1:0] seqPc     = PC_W'(fetchAddr + PC_STEP);
   wire [PC_W-1:0] next_fetch = redirPend ? redirTarget : seqPc; // RQ1 RQ3
   wire            takenNow  = instBranch & instTaken;

   assign rf.spWe      = canIssue & instWriteSp;
   assign rf.ipWe      = canIssue ? instWriteIp : '0;
   assign rf.psWe      = canIssue & instWritePs;
   assign rf.wdata     = instWriteData;
   assign rf.trapTaken = trapTaken;
   assign spValue      = rf.spArch; // RQ7

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fetchAddr   <= PC_RESET;
         redirPend   <= 1'b0;
         redirTarget <= PC_RESET;
      end else if (clkEn && canIssue) begin
         fetchAddr   <= next_fetch; // RQ2 RQ4 RQ14
         redirPend   <= takenNow; // RQ1 RQ2
         redirTarget <= instTarget;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         issueValid    <= 1'b0;
         issuePc       <= PC_RESET;
         issueSrcA     <= IP_RESET;
         issueSrcB     <= IP_RESET;
         issueDest     <= IP_RESET;
         issuePageSize <= PS_RESET;
         stalled       <= 1'b0;
      end else if (clkEn) begin
         issueValid    <= canIssue;
         issuePc       <= fetchAddr;
         issueSrcA     <= absA;
         issueSrcB     <= absB;
         issueDest     <= absD;
         issuePageSize <= rf.psEff; // RQ12
         stalled       <= instValid & ~canIssue;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         memState <= MEM_IDLE;
      end else if (clkEn) begin
         case (memState)
            MEM_IDLE: begin
               if (canIssue && instLoad)
                  memState <= MEM_LOAD;
               else if (canIssue && instStore)
                  memState <= MEM_STORE;
            end
            MEM_LOAD, MEM_STORE: begin
               if (memDone)
                  memState <= MEM_IDLE;
            end
            default: memState <= MEM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         memReq      <= 1'b0;
         memWe       <= 1'b0;
         memAddr     <= SP_RESET;
         memWdata    <= SP_RESET;
         memPageSize <= PS_RESET;
         loadDest    <= IP_RESET;
      end else if (clkEn) begin
         if (canIssue && memOp) begin
            memReq      <= 1'b1;
            memWe       <= instStore;
            memAddr     <= instMemAddr;
            memWdata    <= instStoreData;
            memPageSize <= rf.psEff; // RQ12
            loadDest    <= absD;
         end else if (memDone) begin
            memReq <= 1'b0;
         end
      end
   end

   // Write-back of load data one cycle after the acknowledge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wbValid <= 1'b0;
         wbReg   <= IP_RESET;
         wbData  <= SP_RESET;
      end else if (clkEn) begin
         wbValid <= memDone & loadPending; // RQ6
         wbReg   <= loadDest;
         wbData  <= memRdata;
      end
   end
endmodule

// [epc_mem_model.sv]
`timescale 1ns/100ps
module epc_mem_model
   import epc_pkg::*;
#(
   parameter logic [WORD_W-1:0] RKEY = 32'h5a5a0000
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Memory channel
   input  wire logic              memReq,
   input  wire logic [WORD_W-1:0] memAddr,
   input  wire logic [3:0]        lat,
   output logic                   memAck,
   output logic [WORD_W-1:0]      memRdata
);
   logic [3:0]  cnt;
   logic [15:0] cyc;

   // Read data only valid with the ack; otherwise a moving pattern
   assign memRdata = memAck ? (memAddr ^ RKEY) : {cyc, ~cyc};

   always_ff @(posedge clk_sys) begin
      cyc <= cyc + 16'h1;
      memAck <= 1'b0;
      if (reset) begin
         cnt <= 4'h0;
         cyc <= 16'h0;
      end else if (memReq && !memAck) begin
         if (cnt >= lat) begin
            memAck <= 1'b1;
            cnt <= 4'h0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// [epc_pipe_chk.sv]
`timescale 1ns/100ps
module epc_pipe_chk
   import epc_pkg::*;
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset,
   input wire logic              clkEn,
   // Instruction side
   input wire logic              instValid,
   input wire logic              instBranch,
   input wire logic              instTaken,
   input wire logic [PC_W-1:0]   instTarget,
   input wire logic              instLoad,
   input wire logic              instWriteSp,
   input wire logic [WORD_W-1:0] instWriteData,
   // Issue side
   input wire logic [PC_W-1:0]   fetchAddr,
   input wire logic              issueValid,
   input wire logic [PC_W-1:0]   issuePc,
   input wire logic [WORD_W-1:0] spValue,
   input wire logic              stalled,
   // Memory side
   input wire logic              memReq,
   input wire logic              memWe,
   input wire logic [WORD_W-1:0] memAddr,
   input wire logic              memAck,
   input wire logic [WORD_W-1:0] memRdata,
   input wire logic              wbValid,
   input wire logic [WORD_W-1:0] wbData
);
   logic              prevTk, prevLd, prevSp, pend;
   logic [PC_W-1:0]   prevTgt, pendTgt;
   logic [WORD_W-1:0] prevWd;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset || !clkEn);

   // Inputs held during a stall, so last cycle describes the issued one
   always_ff @(posedge clk_sys) begin
      prevTk <= instValid && instBranch && instTaken;
      prevLd <= instValid && instLoad;
      prevSp <= instValid && instWriteSp;
      prevTgt <= instTarget;
      prevWd <= instWriteData;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pend <= 1'b0;
      end else if (issueValid) begin
         pend <= prevTk;
         pendTgt <= prevTgt;
      end
   end

   sequence memDone;
      memReq && memAck;
   endsequence

   mem_hold_a: assert property (memReq && !memAck |=> memReq
      && $stable(memAddr) && $stable(memWe)) else $error("mem hold");
   mem_drop_a: assert property (memDone |=> !memReq)
      else $error("mem drop");
   load_wb_a: assert property ((memDone and !memWe) |=> wbValid
      && wbData == $past(memRdata)) else $error("load wb");
   mem_start_a: assert property (issueValid && prevLd |-> memReq
      && !memWe) else $error("mem start");
   issue_pc_a: assert property (issueValid |-> issuePc == $past(fetchAddr))
      else $error("issue pc");
   seq_step_a: assert property (issueValid && !pend
      |-> fetchAddr == issuePc + PC_STEP) else $error("seq step");
   slot_redir_a: assert property (issueValid && pend
      |-> fetchAddr == pendTgt) else $error("redirect");
   stall_flag_a: assert property (stalled == ($past(instValid)
      && !issueValid)) else $error("stall flag");
   sp_new_a: assert property (issueValid && prevSp
      |=> spValue == $past(prevWd)) else $error("sp value");
endmodule

bind epc_pipe epc_pipe_chk chk_u (.*);

// [epc_pipe_tb.sv]
`timescale 1ns/100ps
module epc_pipe_tb
   import epc_pkg::*;
;
   typedef struct packed {
      logic [5:0]        f;
      logic [PC_W-1:0]   tgt;
      logic [REG_W-1:0]  a;
      logic [REG_W-1:0]  d;
      logic [WORD_W-1:0] wd;
   } epc_inst_t;

   logic              clk_sys = 1'b0;
   logic              reset = 1'b1;
   logic              instValid = 1'b0;
   logic              clkEn = 1'b1;
   logic              instUseB = 1'b0;
   logic              trapTaken = 1'b0;
   logic [IP_NUM-1:0] instWriteIp = '0;
   logic [REG_W-1:0]  instSrcB = '0;
   logic              instBranch, instTaken, instLoad, instStore;
   logic              instUseA, instUseDest, instWriteSp, instWritePs;
   logic              issueValid, stalled, memReq, memWe, memAck, wbValid;
   logic [PC_W-1:0]   fetchAddr, instTarget, issuePc;
   logic [WORD_W-1:0] instMemAddr, instStoreData, instWriteData, spValue;
   logic [WORD_W-1:0] memAddr, memWdata, memRdata, wbData;
   logic [REG_W-1:0]  instSrcA, instDest, issueSrcA, issueSrcB;
   logic [REG_W-1:0]  issueDest, wbReg, wbR;
   logic [PS_W-1:0]   issuePageSize, memPageSize;
   logic [PS_W-1:0]   lps [64];
   logic [REG_W-1:0]  lsa [64];
   logic [WORD_W-1:0] wbD;
   epc_inst_t         rom [64];
   epc_inst_t         cur;
   int                lc [64];
   int                cyc = 0;
   int                errors = 0;
   int                num_checks = 0;
   logic [PC_W-1:0]   ord [$];
   bit                seen = 0;

   // Instruction memory answers the current fetch address
   assign cur = rom[fetchAddr[5:0]];
   assign {instBranch, instTaken, instLoad, instStore} = cur.f[5:2];
   assign {instWriteSp, instWritePs} = cur.f[1:0];
   assign instTarget = cur.tgt;
   assign instSrcA = cur.a;
   assign instDest = cur.d;
   assign instUseA = |cur.a;
   assign instUseDest = |cur.d;
   assign instMemAddr = cur.wd;
   assign instStoreData = cur.wd;
   assign instWriteData = cur.wd;

   epc_pipe dut_u (.*);
   epc_mem_model mem_u (.clk_sys(clk_sys), .reset(reset), .memReq(memReq),
      .memAddr(memAddr), .lat(4'h3), .memAck(memAck), .memRdata(memRdata));

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (issueValid) begin
         if (ord.size() < 12)
            ord.push_back(issuePc);
         lc[issuePc[5:0]] = cyc;
         lps[issuePc[5:0]] = issuePageSize;
         lsa[issuePc[5:0]] = issueSrcA;
         seen = seen | (issuePc == 30'h1f);
      end
      if (wbValid) begin
         wbR = wbReg;
         wbD = wbData;
      end
   end

   task chk(string n, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, exp, got);
      end
   endtask

   function automatic epc_inst_t mk(logic [5:0] f, logic [29:0] t,
                                     logic [7:0] a, logic [7:0] d,
                                     logic [31:0] w);
      return {f, t, a, d, w};
   endfunction

   task t_branch;
      int e [12] = '{0, 1, 2, 3, 10, 20, 21, 22, 23, 24, 25, 26};
      for (int i = 0; i < 12; i++)
         chk("issue order", 32'(ord[i]), e[i]);
      chk("target gap", lc[10] - lc[3], 1);
   endtask

   task t_load;
      chk("overlap", lc[23] - lc[22], 1);
      chk("use waits", 32'(lc[24] - lc[22] > 4), 1);
      chk("wb reg", 32'(wbR), 5);
      chk("wb data", wbD, 32'h100 ^ 32'h5a5a0000);
   endtask

   task t_regs;
      chk("stack ptr", spValue, 32'h40);
      chk("ps old", 32'(lps[28]), 0);
      chk("ps new", 32'(lps[29]), 2);
      chk("local abs", 32'(lsa[30]), 8'h93);
      chk("global", 32'(lsa[23]), 8'h06);
   endtask

   task summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge clk_sys);
      errors++;
      summarize();
   end

   initial begin
      for (int i = 0; i < 64; i++)
         rom[i] = '0;
      rom[0] = mk(6'h20, 30'h32, 8'h0, 8'h0, 32'h0);
      rom[2] = mk(6'h30, 30'ha, 8'h0, 8'h0, 32'h0);
      rom[3] = mk(6'h30, 30'h14, 8'h0, 8'h0, 32'h0);
      rom[22] = mk(6'h08, 30'h0, 8'h0, 8'h05, 32'h100);
      rom[23] = mk(6'h00, 30'h0, 8'h06, 8'h07, 32'h0);
      rom[24] = mk(6'h00, 30'h0, 8'h05, 8'h08, 32'h0);
      rom[25] = mk(6'h02, 30'h0, 8'h0, 8'h0, 32'h40);
      rom[26] = mk(6'h04, 30'h0, 8'h0, 8'h0, 32'h200);
      rom[27] = mk(6'h01, 30'h0, 8'h0, 8'h0, 32'h2);
      rom[30] = mk(6'h00, 30'h0, 8'h83, 8'h0, 32'h0);
      // Tight loop keeps the fetch inside the table
      rom[31] = mk(6'h30, 30'h1f, 8'h0, 8'h0, 32'h0);
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      instValid <= 1'b1;
      for (int i = 0; i < 300 && !seen; i++)
         @(posedge clk_sys);
      t_branch();
      t_load();
      t_regs();
      summarize();
   end
endmodule
